// ### hdl/can_evt_pkg.sv
// Purpose: shared constants and types for the transmit event queue and
//          standard identifier filter configuration block
// Assumes: AHB-Lite slave with 32-bit data, one word per register
// Notes:   all offsets are byte addresses on the low address bits

package can_evt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W           = 12;
  localparam logic [11:0] OFF_CTRL        = 12'h000;
  localparam logic [11:0] OFF_EVT_STATUS  = 12'h004;
  localparam logic [11:0] OFF_EVT_ACK     = 12'h008;
  localparam logic [11:0] OFF_TIMESTAMP   = 12'h00c;
  localparam logic [11:0] OFF_EVT_WORD0   = 12'h010;
  localparam logic [11:0] OFF_EVT_WORD1   = 12'h014;
  localparam logic [11:0] OFF_STD_FILTER  = 12'h084;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_STD_FILTER  = 32'h0000_0000;
  localparam logic        RST_INIT        = 1'b1;
  localparam logic        RST_CCE         = 1'b0;
  localparam logic        RST_ONE_SHOT    = 1'b0;

  // ----------------------------------------------------------------
  // Control, status and acknowledge bits
  // ----------------------------------------------------------------
  localparam int CTRL_INIT_BIT     = 0;
  localparam int CTRL_CCE_BIT      = 1;
  localparam int CTRL_ONE_SHOT_BIT = 2;
  localparam int ACK_POP_BIT       = 0;
  localparam int ACK_LOST_CLR_BIT  = 1;
  localparam int STAT_FULL_BIT     = 16;
  localparam int STAT_LOST_BIT     = 17;

  // ----------------------------------------------------------------
  // Standard filter configuration fields
  // ----------------------------------------------------------------
  localparam int          LSS_MSB      = 23;
  localparam int          LSS_LSB      = 16;
  localparam int          STD_FILTER_LIST_START_MSB    = 15;
  localparam int          STD_FILTER_LIST_START_LSB    = 2;
  localparam logic [7:0]  LSS_MAX      = 8'h80;

  // ----------------------------------------------------------------
  // Event record fields
  // ----------------------------------------------------------------
  localparam int E0_ESI_BIT   = 31;
  localparam int E0_XTD_BIT   = 30;
  localparam int E0_RTR_BIT   = 29;
  localparam int E0_ID_MSB    = 28;
  localparam int E0_STD_LSB   = 18;
  localparam int E1_MM_MSB    = 31;
  localparam int E1_MM_LSB    = 24;
  localparam int E1_ET_MSB    = 23;
  localparam int E1_ET_LSB    = 22;
  localparam int E1_FDF_BIT   = 21;
  localparam int E1_BRS_BIT   = 20;
  localparam int E1_DLC_MSB   = 19;
  localparam int E1_DLC_LSB   = 16;
  localparam int E1_TS_MSB    = 15;
  localparam logic [1:0] ET_TX_EVENT  = 2'h1;
  localparam logic [1:0] ET_CANCELLED = 2'h2;

  // ----------------------------------------------------------------
  // Queue geometry
  // ----------------------------------------------------------------
  localparam int QUEUE_DEPTH = 8;
  localparam int QPTR_W      = 3;

  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_RD_W1   = 2'b01,
    BUS_RD_W2   = 2'b11,
    BUS_RD_DONE = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic        store_event;
    logic        error_passive;
    logic        extended_id_flag;
    logic        remote;
    logic [28:0] id;
    logic [7:0]  message_marker;
    logic        cancelled;
    logic        fd_format;
    logic        bit_rate_switch;
    logic [3:0]  dlc;
  } tx_report_t;

  typedef struct packed {
    logic        enable;
    logic [7:0]  list_count;
    logic [15:0] start_addr;
  } filter_cfg_t;

  // Data bytes carried by a length code
  function automatic logic [6:0] dlc_bytes(input logic fd, input logic [3:0] dlc);
    logic [6:0] n;
    n = 7'h08;
    if (dlc <= 4'h8) n = {3'h0, dlc};
    else if (fd)
    begin
      case (dlc)
        4'h9:    n = 7'h0c;
        4'ha:    n = 7'h10;
        4'hb:    n = 7'h14;
        4'hc:    n = 7'h18;
        4'hd:    n = 7'h20;
        4'he:    n = 7'h30;
        default: n = 7'h40;
      endcase
    end
    return n;
  endfunction

endpackage

// ### hdl/evt_record_ram.sv
// Purpose: storage for two-word transmit event records
// Assumes: one write and one read port on the same clock
// Notes:   read data is registered, one cycle behind the address

`timescale 1ns/1ps
`default_nettype none

module evt_record_ram
  import can_evt_pkg::*;
(
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // Write port
  input  wire logic                 wr_en,
  input  wire logic [QPTR_W-1:0]    wr_addr,
  input  wire logic [63:0]          wr_data,
  // Read port
  input  wire logic [QPTR_W-1:0]    rd_addr,
  output logic      [63:0]          rd_data
);

  logic [63:0] mem [QUEUE_DEPTH];

  always_ff @(posedge hclk)
  begin
    if (wr_en) mem[wr_addr] <= wr_data;
  end

  // Registered read keeps the array free of reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) rd_data <= 64'h0;
    else rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// ### hdl/can_evt_filter_cfg.sv
// Purpose: transmit event record queue and standard filter configuration
// Assumes: AHB-Lite single word transfers, one transmitter report per pulse
// Notes:   reads take two wait states, writes none

`timescale 1ns/1ps
`default_nettype none

// How it works
// - word0 bit31 shows error passive state
// - word0 bit30 set for extended identifier
// - word0 bit29 set for remote frame
// - identifier in 28:0, standard in 28:18
// - marker byte copied into word1 31:24
// - event type 1 normal, 2 cancelled/one-shot
// - word1 bit21 marks FD format
// - word1 bit20 marks bit rate switching
// - length code kept in 19:16
// - classic codes above eight mean eight bytes
// - FD codes 9-15 map 12 to 64
// - 16-bit timestamp captured in 15:0
// - filter config writable only with cce and init
// - list size above 128 used as 128
// - list size zero disables standard filtering
// - start field bits 15:2 word address
// - filter config applies to standard receive frames
module can_evt_filter_cfg
  import can_evt_pkg::*;
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Transmitter completion
  input  wire logic              tx_done,
  input  wire tx_report_t        tx_report,
  // Receive frame under filtering
  input  wire logic              rx_frame_valid,
  input  wire logic              rx_extended_id,
  // Configuration out
  output filter_cfg_t            std_filter_cfg,
  output logic                   std_filter_apply,
  output logic                   init_mode,
  output logic                   config_change_enable,
  output logic                   one_shot_mode,
  output logic                   evt_pending
);

  // ----------------------------------------------------------------
  // Bus capture
  // ----------------------------------------------------------------
  bus_state_t         bus_state;
  logic               wr_pend;
  logic               rd_take;
  logic [ADDR_W-1:0]  dp_addr;
  logic               take;
  logic               wr_strobe;

  logic [31:0]        std_filter;
  logic [15:0]        ts_count;
  logic [QPTR_W-1:0]  wr_ptr;
  logic [QPTR_W-1:0]  rd_ptr;
  logic [QPTR_W:0]    fill;
  logic               lost;
  logic [63:0]        head;
  logic [63:0]        next_record;
  logic               push;
  logic               pop;
  logic               queue_full;
  logic [31:0]        next_rdata;
  logic [7:0]         lss_field;

  // Transfer taken on a valid address phase while the bus is ready
  assign take = hsel && htrans[1] && hready;
  assign wr_strobe = wr_pend;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      dp_addr <= '0;
    end
    else if (hready)
    begin
      wr_pend <= take && hwrite;
      if (take) dp_addr <= haddr[ADDR_W-1:0];
    end
    else
    begin
      wr_pend <= 1'b0;
    end
  end

  assign rd_take = take && !hwrite;

  // Read wait states give the head record time to settle after a pop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) bus_state <= BUS_IDLE;
    else
    begin
      case (bus_state)
        BUS_IDLE:    bus_state <= rd_take ? BUS_RD_W1 : BUS_IDLE;
        BUS_RD_W1:   bus_state <= BUS_RD_W2;
        BUS_RD_W2:   bus_state <= BUS_RD_DONE;
        BUS_RD_DONE: bus_state <= rd_take ? BUS_RD_W1 : BUS_IDLE;
        default:     bus_state <= BUS_IDLE;
      endcase
    end
  end

  assign hreadyout = (bus_state == BUS_IDLE) || (bus_state == BUS_RD_DONE);
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      init_mode            <= RST_INIT;
      config_change_enable <= RST_CCE;
      one_shot_mode        <= RST_ONE_SHOT;
    end
    else if (wr_strobe && dp_addr == OFF_CTRL)
    begin
      init_mode            <= hwdata[CTRL_INIT_BIT];
      config_change_enable <= hwdata[CTRL_CCE_BIT];
      one_shot_mode        <= hwdata[CTRL_ONE_SHOT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Standard filter configuration
  // ----------------------------------------------------------------
  // write gated by cce and init
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) std_filter <= RST_STD_FILTER;
    else if (wr_strobe && dp_addr == OFF_STD_FILTER
             && config_change_enable && init_mode)
    begin
      std_filter <= '0;
      std_filter[LSS_MSB:LSS_LSB] <= hwdata[LSS_MSB:LSS_LSB];
      std_filter[STD_FILTER_LIST_START_MSB:STD_FILTER_LIST_START_LSB] <= hwdata[STD_FILTER_LIST_START_MSB:STD_FILTER_LIST_START_LSB];
    end
  end

  assign lss_field = std_filter[LSS_MSB:LSS_LSB];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) std_filter_cfg <= '0;
    else
    begin
      std_filter_cfg.enable <= (lss_field != 8'h00);
      std_filter_cfg.list_count <= (lss_field > LSS_MAX) ? LSS_MAX : lss_field;
      std_filter_cfg.start_addr <= {std_filter[STD_FILTER_LIST_START_MSB:STD_FILTER_LIST_START_LSB], 2'b00};
    end
  end

  // only standard identifier frames take this path
  assign std_filter_apply = rx_frame_valid && !rx_extended_id && std_filter_cfg.enable;

  // ----------------------------------------------------------------
  // Timestamp counter
  // ----------------------------------------------------------------
  // Free running; wraps silently, software must track overflow
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) ts_count <= 16'h0000;
    else ts_count <= ts_count + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Event record assembly
  // ----------------------------------------------------------------
  always_comb
  begin
    next_record = 64'h0;
    next_record[E0_ESI_BIT] = tx_report.error_passive;
    next_record[E0_XTD_BIT] = tx_report.extended_id_flag;
    next_record[E0_RTR_BIT] = tx_report.remote;
    if (tx_report.extended_id_flag) next_record[E0_ID_MSB:0] = tx_report.id;
    else next_record[E0_ID_MSB:E0_STD_LSB] = tx_report.id[10:0];
    next_record[32+E1_MM_MSB:32+E1_MM_LSB] = tx_report.message_marker;
    next_record[32+E1_ET_MSB:32+E1_ET_LSB] =
      (tx_report.cancelled || one_shot_mode) ? ET_CANCELLED : ET_TX_EVENT;
    next_record[32+E1_FDF_BIT] = tx_report.fd_format;
    next_record[32+E1_BRS_BIT] = tx_report.bit_rate_switch;
    next_record[32+E1_DLC_MSB:32+E1_DLC_LSB] = tx_report.dlc;
    next_record[32+E1_TS_MSB:32] = ts_count;
  end

  // ----------------------------------------------------------------
  // Event queue pointers
  // ----------------------------------------------------------------
  assign queue_full = (fill == 4'(QUEUE_DEPTH));
  assign push = tx_done && tx_report.store_event && !queue_full;
  assign pop = wr_strobe && dp_addr == OFF_EVT_ACK && hwdata[ACK_POP_BIT]
               && (fill != '0);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (push) wr_ptr <= wr_ptr + 3'h1;
      if (pop) rd_ptr <= rd_ptr + 3'h1;
      if (push && !pop) fill <= fill + 4'h1;
      else if (pop && !push) fill <= fill - 4'h1;
    end
  end

  // Overflow flag; a new loss beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) lost <= 1'b0;
    else if (tx_done && tx_report.store_event && queue_full) lost <= 1'b1;
    else if (wr_strobe && dp_addr == OFF_EVT_ACK && hwdata[ACK_LOST_CLR_BIT])
      lost <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) evt_pending <= 1'b0;
    else evt_pending <= (fill != '0);
  end

  // word0 in low half, read at lower address
  evt_record_ram u_ram (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (push),
    .wr_addr (wr_ptr),
    .wr_data (next_record),
    .rd_addr (rd_ptr),
    .rd_data (head)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0;
    if (dp_addr == OFF_CTRL)
    begin
      next_rdata[CTRL_INIT_BIT]     = init_mode;
      next_rdata[CTRL_CCE_BIT]      = config_change_enable;
      next_rdata[CTRL_ONE_SHOT_BIT] = one_shot_mode;
    end
    else if (dp_addr == OFF_EVT_STATUS)
    begin
      next_rdata[3:0]            = fill;
      next_rdata[10:8]           = rd_ptr;
      next_rdata[STAT_FULL_BIT]  = queue_full;
      next_rdata[STAT_LOST_BIT]  = lost;
      // FD codes map to long payloads
      if (fill != '0)
        next_rdata[30:24] = dlc_bytes(head[32+E1_FDF_BIT],
                                      head[32+E1_DLC_MSB:32+E1_DLC_LSB]);
    end
    else if (dp_addr == OFF_TIMESTAMP) next_rdata[15:0] = ts_count;
    else if (dp_addr == OFF_EVT_WORD0) next_rdata = head[31:0];
    else if (dp_addr == OFF_EVT_WORD1) next_rdata = head[63:32];
    else if (dp_addr == OFF_STD_FILTER) next_rdata = std_filter;
    else next_rdata = 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) hrdata <= 32'h0;
    else if (bus_state == BUS_RD_W2) hrdata <= next_rdata;
  end

  // hsize unused: only whole-word transfers are supported
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:ADDR_W]};

endmodule

`default_nettype wire

// ### test/can_tx_node.sv
// Purpose: transmitter and receive-path stand-in for the event block
// Assumes: one report per call, two cycles per call
// Notes:   released report lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module can_tx_node
  import can_evt_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Transmitter side
  output tx_report_t tx_report,
  output logic       tx_done,
  // Receive side
  output logic       rx_frame_valid,
  output logic       rx_extended_id
);
  logic [15:0] cnt;

  initial
  begin
    tx_done = 1'b0;
    tx_report = '0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn) cnt <= 16'h0;
    else cnt <= cnt + 16'h1;
  end

  // Receive mix changes each cycle
  assign rx_frame_valid = cnt[0];
  assign rx_extended_id = cnt[1];

  // ----------
  // Report
  // ----------
  // store request
  task automatic send(input tx_report_t r, output logic [15:0] at);
    tx_done <= 1'b1;
    tx_report <= r;
    @(posedge hclk);
    // Counter settles after the edge that takes the report
    #1;
    at = cnt;
    tx_done <= 1'b0;
    tx_report <= ~r;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ### test/can_evt_chk.sv
// Purpose: port checks for the event and filter block
// Assumes: sees the top module ports only
// Notes:   bound after the module
`timescale 1ns/1ps
`default_nettype none
module can_evt_chk
  import can_evt_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Frames and configuration
  input wire logic        tx_done,
  input wire tx_report_t  tx_report,
  input wire logic        rx_frame_valid,
  input wire logic        rx_extended_id,
  input wire filter_cfg_t std_filter_cfg,
  input wire logic        std_filter_apply,
  input wire logic        init_mode,
  input wire logic        config_change_enable,
  input wire logic        evt_pending
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel && htrans[1] && hready;

  sequence rd_wait;
    !hreadyout ##1 !hreadyout ##1 hreadyout;
  endsequence

  // ----------
  // Checks
  // ----------
  read_wait_a: assert property (take && !hwrite |=> rd_wait)
    else $error("read wait states wrong");
  write_zero_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("error response");
  apply_std_a: assert property (std_filter_apply == (rx_frame_valid && !rx_extended_id && std_filter_cfg.enable))
    else $error("filter applied to wrong frame");
  size_clamp_a: assert property (std_filter_cfg.list_count <= LSS_MAX)
    else $error("list size above limit");
  zero_off_a: assert property (std_filter_cfg.enable == (std_filter_cfg.list_count != 8'h00))
    else $error("enable does not follow size");
  start_word_a: assert property (std_filter_cfg.start_addr[1:0] == 2'b00)
    else $error("start not word aligned");
  cfg_lock_a: assert property ((!(init_mode && config_change_enable))[*3] |-> $stable(std_filter_cfg))
    else $error("filter config changed while locked");
  evt_store_a: assert property (tx_done && tx_report.store_event && !evt_pending |-> ##[1:2] evt_pending)
    else $error("stored event not pending");
endmodule

bind can_evt_filter_cfg can_evt_chk chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .tx_done(tx_done),
  .tx_report(tx_report), .rx_frame_valid(rx_frame_valid), .rx_extended_id(rx_extended_id),
  .std_filter_cfg(std_filter_cfg), .std_filter_apply(std_filter_apply),
  .init_mode(init_mode), .config_change_enable(config_change_enable),
  .evt_pending(evt_pending)
);
`default_nettype wire

// ### test/can_evt_filter_cfg_tb.sv
// Purpose: register and event record tests
// Assumes: hready taken from hreadyout
// Notes:   timestamps checked as gaps, absolute start is open
`timescale 1ns/1ps
`default_nettype none
module can_evt_filter_cfg_tb
  import can_evt_pkg::*;
;
  logic             hclk = 1'b0;
  logic             hresetn = 1'b0;
  logic             hsel = 1'b0;
  logic [31:0]      haddr = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [31:0]      hwdata = 32'h0;
  wire logic        hreadyout;
  wire logic        tx_done;
  wire logic        rx_frame_valid;
  wire logic        rx_extended_id;
  wire logic [31:0] hrdata;
  wire tx_report_t  tx_report;
  wire filter_cfg_t std_filter_cfg;
  int               err_total = 0;
  int               checks_done = 0;
  logic [31:0]      rd;
  logic [15:0]      at;
  logic [15:0]      prev_at;
  logic [15:0]      prev_ts;
  tx_report_t       r;
  logic [6:0]       fdmap [0:6] = '{7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
  logic [7:0]       std_filter_list_size [0:4] = '{8'h00, 8'h01, 8'h80, 8'h81, 8'hff};
  logic [7:0]       lss_use [0:4] = '{8'h00, 8'h01, 8'h80, 8'h80, 8'h80};

  can_evt_filter_cfg dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .tx_done(tx_done),
    .tx_report(tx_report), .rx_frame_valid(rx_frame_valid),
    .rx_extended_id(rx_extended_id), .std_filter_cfg(std_filter_cfg),
    .std_filter_apply(), .init_mode(), .config_change_enable(), .one_shot_mode(),
    .evt_pending()
  );
  can_tx_node node_u (
    .hclk(hclk), .hresetn(hresetn), .tx_report(tx_report), .tx_done(tx_done),
    .rx_frame_valid(rx_frame_valid), .rx_extended_id(rx_extended_id)
  );

  // ----------
  // Tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready seen at the falling edge holds for the next rising edge
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 64)
    begin
      n++;
      @(negedge hclk);
    end
    if (n >= 64) chk("hreadyout", 32'h0, 32'h1);
    d = hrdata;
    @(posedge hclk);
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
    logic [31:0] x;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_rdy(x);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rd);
    chk(nm, rd & m, exp);
  endtask

  function automatic logic [6:0] nbytes(input logic fd, input logic [3:0] c);
    if (c <= 4'h8) return {3'h0, c};
    return fd ? fdmap[c - 4'h9] : 7'h08;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------
  // Clock, watchdog and tests
  // ----------
  initial forever #12.5 hclk = ~hclk;

  initial
  begin
    #500000;
    err_total++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("ctrl", OFF_CTRL, 32'hffff_ffff, 32'h1);
    rdchk("sfc", OFF_STD_FILTER, 32'hffff_ffff, 32'h0);
    wr(12'h3f0, 32'hffff_ffff);
    rdchk("unmapped", 12'h3f0, 32'hffff_ffff, 32'h0);
    wr(OFF_STD_FILTER, 32'h0001_0004);
    rdchk("locked", OFF_STD_FILTER, 32'hffff_ffff, 32'h0);
    wr(OFF_CTRL, 32'h3);
    wr(OFF_STD_FILTER, 32'hffff_ffff);
    rdchk("sfc", OFF_STD_FILTER, 32'hffff_ffff, 32'h00ff_fffc);
    chk("start", {16'h0, std_filter_cfg.start_addr}, 32'h0000_fffc);
    for (int k = 0; k < 5; k++)
    begin
      wr(OFF_STD_FILTER, {8'h0, std_filter_list_size[k], 16'h0100});
      rdchk("lss", OFF_STD_FILTER, 32'h00ff_0000, {8'h0, std_filter_list_size[k], 16'h0});
      chk("count", {24'h0, std_filter_cfg.list_count}, {24'h0, lss_use[k]});
      chk("enable", {31'h0, std_filter_cfg.enable}, {31'h0, lss_use[k] != 8'h0});
    end
    wr(OFF_CTRL, 32'h2);
    wr(OFF_STD_FILTER, 32'h0005_0010);
    rdchk("cce only", OFF_STD_FILTER, 32'hffff_ffff, 32'h00ff_0100);
    wr(OFF_CTRL, 32'h0);
    $display("test filter done");
    prev_at = 16'h0;
    prev_ts = 16'h0;
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 16; i++)
      begin
        r = '0;
        r.store_event = 1'b1;
        r.error_passive = i[0];
        r.extended_id_flag = i[1];
        r.remote = i[2];
        r.id = i[1] ? (29'h1a5c_3e10 | 29'(i)) : (29'h700 | 29'(i));
        r.message_marker = {3'h5, 1'(j), 4'(i)};
        r.cancelled = (i == 5);
        r.fd_format = 1'(j);
        r.bit_rate_switch = 1'(j) & i[3];
        r.dlc = 4'(i);
        node_u.send(r, at);
        rdchk("status", OFF_EVT_STATUS, 32'h7f00_000f, {1'b0, nbytes(r.fd_format, r.dlc), 24'h1});
        rdchk("word0", OFF_EVT_WORD0, 32'hffff_ffff, {r.error_passive, r.extended_id_flag, r.remote, r.extended_id_flag ? r.id : {r.id[10:0], 18'h0}});
        xfer(1'b0, OFF_EVT_WORD1, 32'h0, rd);
        chk("word1", {16'h0, rd[31:16]}, {16'h0, r.message_marker, (r.cancelled ? 2'h2 : 2'h1), r.fd_format, r.bit_rate_switch, r.dlc});
        if (i + j > 0) chk("stamp gap", {16'h0, 16'(rd[15:0] - prev_ts)}, {16'h0, 16'(at - prev_at)});
        prev_ts = rd[15:0];
        prev_at = at;
        wr(OFF_EVT_ACK, 32'h1);
      end
    wr(OFF_CTRL, 32'h4);
    node_u.send(r, at);
    xfer(1'b0, OFF_EVT_WORD1, 32'h0, rd);
    chk("one shot", {30'h0, rd[23:22]}, 32'h2);
    wr(OFF_EVT_ACK, 32'h1);
    wr(OFF_CTRL, 32'h0);
    $display("test records done");
    r.store_event = 1'b0;
    node_u.send(r, at);
    rdchk("nostore", OFF_EVT_STATUS, 32'h0003_000f, 32'h0);
    r.store_event = 1'b1;
    repeat (9) node_u.send(r, at);
    rdchk("full", OFF_EVT_STATUS, 32'h0003_000f, 32'h0003_0008);
    wr(OFF_EVT_ACK, 32'h2);
    rdchk("lost clear", OFF_EVT_STATUS, 32'h0003_000f, 32'h0001_0008);
    repeat (9) wr(OFF_EVT_ACK, 32'h1);
    rdchk("empty", OFF_EVT_STATUS, 32'h0003_000f, 32'h0);
    $display("test queue done");
    conclude();
  end
endmodule
`default_nettype wire
